// File: ssbr_map.svh
// Register indexes, field positions, reset values and timing counts
`ifndef SSBR_MAP_SVH
`define SSBR_MAP_SVH

`define SSBR_IDX_STATUS   3'h0
`define SSBR_IDX_DIVISOR  3'h1
`define SSBR_IDX_CTRL     3'h2
`define SSBR_IDX_TXHOLD   3'h3
`define SSBR_IDX_RXHOLD   3'h4
`define SSBR_IDX_ISTAT    3'h5
`define SSBR_IDX_IMASK    3'h6

`define SSBR_ST_TX_HOLDING_EMPTY_FLAG      7
`define SSBR_ST_RX_HOLDING_FULL_FLAG      6
`define SSBR_ST_PER       3
`define SSBR_ST_TRANSMIT_END_FLAG      2
`define SSBR_ST_RX_MULTIPROC_BIT      1
`define SSBR_ST_TX_MULTIPROC_BIT      0

`define SSBR_CT_RE        0
`define SSBR_CT_TE        1
`define SSBR_CT_SYNC      2
`define SSBR_CT_MP        3
`define SSBR_CT_PEN       4
`define SSBR_CT_PM        5
`define SSBR_CT_CKS_LO    6
`define SSBR_CT_CKS_HI    7

`define SSBR_IRQ_RXF      0
`define SSBR_IRQ_TXE      1
`define SSBR_IRQ_TRANSMIT_END_FLAG     2
`define SSBR_IRQ_PER      3

`define SSBR_DIVISOR_RST  8'hFF
`define SSBR_CTRL_RST     8'h00
`define SSBR_ZERO8        8'h00

`define SSBR_FMAX_ASYNC   6'h3F
`define SSBR_FMAX_SYNC    6'h07
`define SSBR_HALF_ASYNC   6'h1F
`define SSBR_HALF_SYNC    6'h03
`define SSBR_LAST_BIT     3'h7

`define SSBR_PRE_DIV1     6'h00
`define SSBR_PRE_DIV4     6'h03
`define SSBR_PRE_DIV16    6'h0F
`define SSBR_PRE_DIV64    6'h3F

`endif

// File: ssbr_pkg.sv
// Types shared by the serial status and bit-rate block
package ssbr_pkg;

   typedef logic [7:0] ssbr_byte_t;

   typedef enum logic [2:0] {
      SER_IDLE  = 3'b000,
      SER_START = 3'b001,
      SER_DATA  = 3'b010,
      SER_EXTRA = 3'b011,
      SER_STOP  = 3'b100
   } ssbr_ser_e;

endpackage

// File: ssbr_rate_if.sv
// Link between the register core and the bit-rate generator
`timescale 1ns/100ps
interface ssbr_rate_if;
   logic [7:0] divisor;
   logic [1:0] clk_sel;
   logic       base_tick;

   modport gen  (input divisor, input clk_sel, output base_tick);
   modport core (output divisor, output clk_sel, input base_tick);
endinterface // ssbr_rate_if

// File: ssbr_rate_gen.sv
// Prescaler and divisor counter of the bit-rate generator
`timescale 1ns/100ps
`include "ssbr_map.svh"
module ssbr_rate_gen (
   input wire logic    mclk,
   input wire logic    arst_n,
   ssbr_rate_if.gen    rif
);

   logic [5:0] pre_q;
   logic [7:0] div_q;
   logic       tick_q;
   wire        pre_wrap;
   wire        div_wrap;

   function automatic logic [5:0] pre_limit(input logic [1:0] sel);
      case (sel)
         2'h0:    pre_limit = `SSBR_PRE_DIV1;
         2'h1:    pre_limit = `SSBR_PRE_DIV4;
         2'h2:    pre_limit = `SSBR_PRE_DIV16;
         default: pre_limit = `SSBR_PRE_DIV64;
      endcase
   endfunction

   // Compare with >= so a smaller setting written mid-count takes at once
   assign pre_wrap = pre_q >= pre_limit(rif.clk_sel); // see RQ17
   assign div_wrap = div_q >= rif.divisor; // see RQ14
   assign rif.base_tick = tick_q;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q  <= 6'h00;
         div_q  <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         pre_q  <= pre_wrap ? 6'h00 : pre_q + 6'h01;
         if (pre_wrap)
            div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
         tick_q <= pre_wrap & div_wrap;
      end
   end

endmodule // ssbr_rate_gen

// File: ssbr_serial.sv
// Serial status flags, bit-rate register and shift engine, Wishbone slave
`timescale 1ns/100ps
`include "ssbr_map.svh"
// What this block does
// RQ1 - Parity error flag sets when data ones plus parity bit mismatch parity mode.
// RQ2 - Parity error flag clears only by writing 0 after reading it as 1.
// RQ3 - Dropping receive enable leaves the parity error flag as it was.
// RQ4 - On parity error the byte is stored but receive-full stays unset.
// RQ5 - Parity error stops reception; in synchronous mode transmission as well.
// RQ6 - Transmit end flag is read-only and starts at 1.
// RQ7 - Transmit end clears with empty-flag clear or a transmit holding write.
// RQ8 - Transmit end sets when the last bit leaves with holding empty.
// RQ9 - Transmit end sets when transmit enable is cleared.
// RQ10 - Received multiprocessor bit is captured into a read-only bit, reset 0.
// RQ11 - Received multiprocessor bit holds when receive enable is cleared.
// RQ12 - Software multiprocessor bit, reset 0, is appended to each sent character.
// RQ13 - Multiprocessor transmit bit unused in sync, without multiproc, or tx off.
// RQ14 - Eight-bit divisor with clock select sets the bit rate.
// RQ15 - Divisor resets to all ones on reset and low-power entry.
// RQ16 - Divisor is readable and writable at any time; the code ignores divisor writes while the low-power request is held.
// RQ17 - Clock select picks full, quarter, sixteenth or sixty-fourth clock.
// RQ18 - Bit period is 64 (async) or 8 (sync) times 4^n times N+1.
// RQ19 - Writing 1 to the parity error flag does nothing.
module ssbr_serial (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output wire logic [31:0] wb_dat_o,
   output wire logic        wb_ack_o,
   input  wire logic        rxd,
   output wire logic        txd,
   output wire logic        sclk,
   input  wire logic        lowpower_req,
   output wire logic        irq
);

   ssbr_rate_if rif ();

   ssbr_rate_gen u_rate (
      .mclk   (mclk),
      .arst_n (arst_n),
      .rif    (rif)
   );

   logic                 ack_q;
   logic [31:0]          dat_q;
   logic [7:0]           divisor_q;
   logic [7:0]           ctrl_q;
   ssbr_pkg::ssbr_byte_t txh_q;
   ssbr_pkg::ssbr_byte_t rxh_q;
   logic [3:0]           istat_q;
   logic [3:0]           imask_q;
   logic                 irq_q;
   logic                 tx_holding_empty_flag_q;
   logic                 rx_holding_full_flag_q;
   logic                 per_q;
   logic                 transmit_end_flag_q;
   logic                 rx_multiproc_bit_q;
   logic                 tx_multiproc_bit_q;
   logic                 tx_holding_empty_flag_seen_q;
   logic                 rx_holding_full_flag_seen_q;
   logic                 per_seen_q;
   logic                 te_q;
   logic                 rxd_m_q;
   logic                 rxd_s_q;
   logic                 lp_m_q;
   logic                 lp_s_q;
   ssbr_pkg::ssbr_ser_e  tx_st_q;
   ssbr_pkg::ssbr_ser_e  rx_st_q;
   logic [5:0]           tx_ph_q;
   logic [5:0]           rx_ph_q;
   logic [2:0]           tx_cnt_q;
   logic [2:0]           rx_cnt_q;
   ssbr_pkg::ssbr_byte_t tx_sh_q;
   ssbr_pkg::ssbr_byte_t rx_sh_q;
   logic                 tx_ext_q;
   logic                 rx_ext_q;
   logic                 txd_q;
   logic                 sclk_q;

   function automatic logic ones_odd(input ssbr_pkg::ssbr_byte_t b);
      ones_odd = ^b;
   endfunction

   // Bus decode; every access is acked one cycle after the request
   wire       req      = wb_cyc_i & wb_stb_i;
   wire       acc      = req & ack_q;
   wire [2:0] idx      = wb_adr_i[4:2];
   wire [7:0] wdat     = wb_dat_i[7:0];
   wire       wr       = acc & wb_we_i & wb_sel_i[0];
   wire       rd       = acc & ~wb_we_i;
   wire       wr_stat  = wr & (idx == `SSBR_IDX_STATUS);
   wire       wr_div   = wr & (idx == `SSBR_IDX_DIVISOR);
   wire       wr_ctrl  = wr & (idx == `SSBR_IDX_CTRL);
   wire       wr_txh   = wr & (idx == `SSBR_IDX_TXHOLD);
   wire       wr_istat = wr & (idx == `SSBR_IDX_ISTAT);
   wire       wr_imask = wr & (idx == `SSBR_IDX_IMASK);
   wire       rd_stat  = rd & (idx == `SSBR_IDX_STATUS);
   wire       rd_rxh   = rd & (idx == `SSBR_IDX_RXHOLD);

   // Control fields
   wire       rx_en  = ctrl_q[`SSBR_CT_RE];
   wire       tx_en  = ctrl_q[`SSBR_CT_TE];
   wire       sync   = ctrl_q[`SSBR_CT_SYNC];
   wire       mp_en  = ctrl_q[`SSBR_CT_MP];
   wire       par_en = ctrl_q[`SSBR_CT_PEN];
   wire       pm     = ctrl_q[`SSBR_CT_PM];
   wire       ext_on = ~sync & (mp_en | par_en);

   wire [7:0] status = {tx_holding_empty_flag_q, rx_holding_full_flag_q, 2'b00, per_q, transmit_end_flag_q, rx_multiproc_bit_q,
                        tx_multiproc_bit_q};
   wire [7:0] rd_mux =
      (idx == `SSBR_IDX_STATUS)  ? status :
      (idx == `SSBR_IDX_DIVISOR) ? divisor_q :
      (idx == `SSBR_IDX_CTRL)    ? ctrl_q :
      (idx == `SSBR_IDX_TXHOLD)  ? txh_q :
      (idx == `SSBR_IDX_RXHOLD)  ? rxh_q :
      (idx == `SSBR_IDX_ISTAT)   ? {4'h0, istat_q} :
      (idx == `SSBR_IDX_IMASK)   ? {4'h0, imask_q} : `SSBR_ZERO8;

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign rif.divisor = divisor_q; // see RQ14
   assign rif.clk_sel = {ctrl_q[`SSBR_CT_CKS_HI], ctrl_q[`SSBR_CT_CKS_LO]};
   assign txd  = txd_q;
   assign sclk = sclk_q;
   assign irq  = irq_q;

   // Bit phase: 64 base ticks per bit async, 8 sync
   wire [5:0] fmax = sync ? `SSBR_FMAX_SYNC : `SSBR_FMAX_ASYNC; // see RQ18
   wire [5:0] half = sync ? `SSBR_HALF_SYNC : `SSBR_HALF_ASYNC;
   wire       tx_bit_end = rif.base_tick & (tx_ph_q == fmax);

   // Synchronous mode stalls both directions on a parity error
   wire sync_hold = sync & per_q; // see RQ5
   wire tx_load = tx_en & ~tx_holding_empty_flag_q & ~sync_hold & tx_bit_end
                  & (tx_st_q == ssbr_pkg::SER_IDLE);
   wire tx_last = tx_bit_end & ((tx_st_q == ssbr_pkg::SER_STOP)
                  | (sync & (tx_st_q == ssbr_pkg::SER_DATA)
                     & (tx_cnt_q == `SSBR_LAST_BIT)));
   // Multiprocessor bit only in async multiprocessor frames with tx on
   wire tx_ext = mp_en ? tx_multiproc_bit_q
                       : (ones_odd(tx_sh_q) ^ pm); // see RQ12, RQ13

   // Receive sampling
   wire rx_samp = rif.base_tick
                  & ((sync ? tx_ph_q : rx_ph_q) == half);
   wire rx_start = ~sync & rx_en & ~per_q & ~rxd_s_q
                   & (rx_st_q == ssbr_pkg::SER_IDLE); // see RQ5
   wire rx_sstart = sync & rx_en & ~per_q & tx_bit_end
                    & (rx_st_q == ssbr_pkg::SER_IDLE); // see RQ5
   wire rx_done = rx_samp & ((rx_st_q == ssbr_pkg::SER_STOP)
                  | (sync & (rx_st_q == ssbr_pkg::SER_DATA)
                     & (rx_cnt_q == `SSBR_LAST_BIT)));
   wire [7:0] rx_word = sync ? {rxd_s_q, rx_sh_q[7:1]} : rx_sh_q;
   wire rx_perr = ~sync & par_en & ~mp_en
                  & ((ones_odd(rx_word) ^ rx_ext_q) != pm); // see RQ1

   // Flag events
   wire te_fall  = te_q & ~tx_en;
   wire per_set  = rx_done & rx_perr; // see RQ1
   wire rx_holding_full_flag_set = rx_done & ~rx_perr; // see RQ4
   wire tx_holding_empty_flag_set = tx_load | te_fall;
   wire transmit_end_flag_set = (tx_last & tx_holding_empty_flag_q) | te_fall; // see RQ8, RQ9
   wire per_clr  = wr_stat & ~wdat[`SSBR_ST_PER] & per_seen_q; // see RQ2, RQ19
   wire rx_holding_full_flag_clr = (wr_stat & ~wdat[`SSBR_ST_RX_HOLDING_FULL_FLAG] & rx_holding_full_flag_seen_q) | rd_rxh;
   wire tx_holding_empty_flag_clr = (wr_stat & ~wdat[`SSBR_ST_TX_HOLDING_EMPTY_FLAG] & tx_holding_empty_flag_seen_q) | wr_txh;
   wire [3:0] ev = {per_set, transmit_end_flag_set, tx_holding_empty_flag_set, rx_holding_full_flag_set};

   // Bus slave
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         if (req & ~ack_q)
            dat_q <= {24'h00_0000, rd_mux};
      end
   end

   // Pin synchronisers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rxd_m_q <= 1'b1;
         rxd_s_q <= 1'b1;
         lp_m_q  <= 1'b0;
         lp_s_q  <= 1'b0;
      end else begin
         rxd_m_q <= rxd;
         rxd_s_q <= rxd_m_q;
         lp_m_q  <= lowpower_req;
         lp_s_q  <= lp_m_q;
      end
   end

   // Software registers; low-power entry reloads the divisor
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         divisor_q <= `SSBR_DIVISOR_RST; // see RQ15
         ctrl_q    <= `SSBR_CTRL_RST;
         txh_q     <= `SSBR_ZERO8;
         imask_q   <= 4'h0;
         tx_multiproc_bit_q    <= 1'b0; // see RQ12
         te_q      <= 1'b0;
      end else begin
         if (lp_s_q)
            divisor_q <= `SSBR_DIVISOR_RST; // see RQ15
         else if (wr_div)
            divisor_q <= wdat; // see RQ16
         if (wr_ctrl)
            ctrl_q <= wdat;
         if (wr_txh)
            txh_q <= wdat;
         if (wr_imask)
            imask_q <= wdat[3:0];
         if (wr_stat)
            tx_multiproc_bit_q <= wdat[`SSBR_ST_TX_MULTIPROC_BIT];
         te_q <= tx_en;
      end
   end

   // Status flags; a hardware set wins over a software clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_holding_empty_flag_q      <= 1'b1;
         rx_holding_full_flag_q      <= 1'b0;
         per_q       <= 1'b0;
         transmit_end_flag_q      <= 1'b1; // see RQ6
         tx_holding_empty_flag_seen_q <= 1'b0;
         rx_holding_full_flag_seen_q <= 1'b0;
         per_seen_q  <= 1'b0;
      end else begin
         tx_holding_empty_flag_q <= tx_holding_empty_flag_set | (tx_holding_empty_flag_q & ~tx_holding_empty_flag_clr);
         rx_holding_full_flag_q <= rx_holding_full_flag_set | (rx_holding_full_flag_q & ~rx_holding_full_flag_clr); // see RQ4
         // Receive enable plays no part here, so dropping it keeps the flag
         per_q  <= per_set | (per_q & ~per_clr); // see RQ2, RQ3
         // No write path: the bit is read-only
         transmit_end_flag_q <= transmit_end_flag_set | (transmit_end_flag_q & ~tx_holding_empty_flag_clr); // see RQ6, RQ7
         if (rd_stat) begin
            tx_holding_empty_flag_seen_q <= tx_holding_empty_flag_q;
            rx_holding_full_flag_seen_q <= rx_holding_full_flag_q;
            per_seen_q  <= per_q; // see RQ2
         end else if (wr_stat) begin
            tx_holding_empty_flag_seen_q <= 1'b0;
            rx_holding_full_flag_seen_q <= 1'b0;
            per_seen_q  <= 1'b0;
         end
      end
   end

   // Interrupt status, write one to clear, events win
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         istat_q <= 4'h0;
         irq_q   <= 1'b0;
      end else begin
         istat_q <= ev | (istat_q & ~(wr_istat ? wdat[3:0] : 4'h0));
         irq_q   <= |(istat_q & imask_q);
      end
   end

   // Transmitter
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tx_ph_q  <= 6'h00;
         tx_st_q  <= ssbr_pkg::SER_IDLE;
         tx_cnt_q <= 3'h0;
         tx_sh_q  <= `SSBR_ZERO8;
         tx_ext_q <= 1'b1;
      end else begin
         if (rif.base_tick)
            tx_ph_q <= tx_bit_end ? 6'h00 : tx_ph_q + 6'h01; // see RQ18
         if (!tx_en) begin
            tx_st_q <= ssbr_pkg::SER_IDLE;
         end else if (tx_load) begin
            tx_sh_q  <= txh_q;
            tx_cnt_q <= 3'h0;
            tx_st_q  <= sync ? ssbr_pkg::SER_DATA : ssbr_pkg::SER_START;
         end else if (tx_bit_end) begin
            unique case (tx_st_q)
               ssbr_pkg::SER_IDLE: tx_st_q <= ssbr_pkg::SER_IDLE;
               ssbr_pkg::SER_START: tx_st_q <= ssbr_pkg::SER_DATA;
               ssbr_pkg::SER_DATA: begin
                  tx_cnt_q <= tx_cnt_q + 3'h1;
                  if (tx_cnt_q == `SSBR_LAST_BIT) begin
                     tx_ext_q <= tx_ext;
                     tx_st_q  <= sync ? ssbr_pkg::SER_IDLE :
                                 ext_on ? ssbr_pkg::SER_EXTRA :
                                 ssbr_pkg::SER_STOP;
                  end else begin
                     tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                  end
               end
               ssbr_pkg::SER_EXTRA: tx_st_q <= ssbr_pkg::SER_STOP;
               ssbr_pkg::SER_STOP: tx_st_q <= ssbr_pkg::SER_IDLE;
               default: tx_st_q <= ssbr_pkg::SER_IDLE;
            endcase
         end
      end
   end

   // Line and serial clock outputs
   wire txd_d = (tx_st_q == ssbr_pkg::SER_START) ? 1'b0 :
                (tx_st_q == ssbr_pkg::SER_DATA)  ? tx_sh_q[0] :
                (tx_st_q == ssbr_pkg::SER_EXTRA) ? tx_ext_q : 1'b1;
   wire sclk_d = ~(sync & (tx_st_q == ssbr_pkg::SER_DATA)
                   & (tx_ph_q <= half));

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         txd_q  <= 1'b1;
         sclk_q <= 1'b1;
      end else begin
         txd_q  <= txd_d;
         sclk_q <= sclk_d;
      end
   end

   // Receiver; disabling it abandons the frame but touches no flag
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_ph_q  <= 6'h00;
         rx_st_q  <= ssbr_pkg::SER_IDLE;
         rx_cnt_q <= 3'h0;
         rx_sh_q  <= `SSBR_ZERO8;
         rx_ext_q <= 1'b0;
      end else begin
         if (rx_start)
            rx_ph_q <= 6'h00;
         else if (rif.base_tick)
            rx_ph_q <= (rx_ph_q == fmax) ? 6'h00 : rx_ph_q + 6'h01;
         if (!rx_en || sync_hold) begin
            rx_st_q <= ssbr_pkg::SER_IDLE; // see RQ3, RQ5, RQ11
         end else if (rx_start) begin
            rx_st_q <= ssbr_pkg::SER_START;
         end else if (rx_sstart) begin
            rx_cnt_q <= 3'h0;
            rx_st_q  <= ssbr_pkg::SER_DATA;
         end else if (rx_samp) begin
            unique case (rx_st_q)
               ssbr_pkg::SER_IDLE: rx_st_q <= ssbr_pkg::SER_IDLE;
               ssbr_pkg::SER_START: begin
                  rx_cnt_q <= 3'h0;
                  rx_st_q  <= rxd_s_q ? ssbr_pkg::SER_IDLE
                                      : ssbr_pkg::SER_DATA;
               end
               ssbr_pkg::SER_DATA: begin
                  rx_sh_q  <= {rxd_s_q, rx_sh_q[7:1]};
                  rx_cnt_q <= rx_cnt_q + 3'h1;
                  if (rx_cnt_q == `SSBR_LAST_BIT)
                     rx_st_q <= sync ? ssbr_pkg::SER_IDLE :
                                ext_on ? ssbr_pkg::SER_EXTRA :
                                ssbr_pkg::SER_STOP;
               end
               ssbr_pkg::SER_EXTRA: begin
                  rx_ext_q <= rxd_s_q;
                  rx_st_q  <= ssbr_pkg::SER_STOP;
               end
               ssbr_pkg::SER_STOP: rx_st_q <= ssbr_pkg::SER_IDLE;
               default: rx_st_q <= ssbr_pkg::SER_IDLE;
            endcase
         end
      end
   end

   // Received byte and multiprocessor bit; stored even on parity error
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rxh_q  <= `SSBR_ZERO8;
         rx_multiproc_bit_q <= 1'b0; // see RQ10
      end else if (rx_done && rx_en) begin
         rxh_q <= rx_word; // see RQ4
         if (mp_en && !sync)
            rx_multiproc_bit_q <= rx_ext_q; // see RQ10, RQ11
      end
   end

   // Checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   sequence s_per_clear;
      wr_stat && !wdat[`SSBR_ST_PER] && per_seen_q && !per_set;
   endsequence

   sequence s_per_blind_write;
      wr_stat && per_q && !per_seen_q;
   endsequence

   a_per_set_on_err: assert property ( // see RQ1
      per_set |=> per_q && rxh_q == $past(rx_word))
      else $error("parity error not flagged");
   a_per_clear_seq: assert property (s_per_clear |=> !per_q) // see RQ2
      else $error("parity flag not cleared");
   a_per_blind_hold: assert property (s_per_blind_write |=> per_q) // see RQ2
      else $error("parity flag cleared without read");
   a_per_re_drop: assert property ( // see RQ3
      per_q && $fell(rx_en) |=> per_q)
      else $error("parity flag lost on enable drop");
   a_per_no_full: assert property ( // see RQ4
      per_set && !rx_holding_full_flag_q |=> !rx_holding_full_flag_q)
      else $error("receive full set on parity error");
   a_per_stops_rx: assert property ( // see RQ5
      per_q && rx_st_q == ssbr_pkg::SER_IDLE |=>
      rx_st_q == ssbr_pkg::SER_IDLE)
      else $error("reception started during parity error");
   a_sync_tx_hold: assert property ( // see RQ5
      sync && per_q |-> !tx_load)
      else $error("sync transmit during parity error");
   a_transmit_end_flag_txh_write: assert property ( // see RQ7
      wr_txh && !transmit_end_flag_set |=> !transmit_end_flag_q)
      else $error("transmit end not cleared by write");
   a_transmit_end_flag_last_bit: assert property ( // see RQ8
      tx_last && tx_holding_empty_flag_q && tx_en |=> transmit_end_flag_q)
      else $error("transmit end not set at last bit");
   a_transmit_end_flag_te_drop: assert property ( // see RQ9
      $fell(tx_en) |=> ##1 transmit_end_flag_q && tx_holding_empty_flag_q)
      else $error("transmit end not set on disable");
   a_rx_multiproc_bit_hold: assert property (!rx_en |=> $stable(rx_multiproc_bit_q)) // see RQ11
      else $error("multiproc bit changed while disabled");
   a_div_lowpower: assert property ( // see RQ15
      lp_s_q |=> divisor_q == `SSBR_DIVISOR_RST)
      else $error("divisor not reloaded on low power");
   a_div_write: assert property ( // see RQ16
      wr_div && !lp_s_q |=> divisor_q == $past(wdat))
      else $error("divisor write lost");

endmodule // ssbr_serial

// File: ssbr_far_end.sv
// Model of the remote serial device on the line side
`timescale 1ns/100ps
module ssbr_far_end #(
   parameter int BIT_CYC = 64
) (
   input  wire logic mclk,
   input  wire logic txd,
   output logic      rxd
);
   initial rxd = 1'b1;

   // Start, data LSB first, even parity (inverted when bad), stop
   task automatic send(input logic [7:0] d, input logic bad);
      logic [10:0] f;
      f = {1'b1, ^d ^ bad, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (BIT_CYC) @(posedge mclk);
      end
   endtask

   // Samples mid-bit, so a wrong bit period garbles the byte
   task automatic recv(output logic [9:0] f);
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT_CYC) @(posedge mclk);
         f[i] = txd;
      end
   endtask
endmodule // ssbr_far_end

// File: ssbr_serial_bench.sv
// Self-checking bench for the serial status and bit-rate block
`timescale 1ns/100ps
module ssbr_serial_bench;
   logic        mclk, arst_n, cyc, stb, we, lp, rxd, ack, txd, irq;
   logic [4:0]  adr;
   logic [31:0] dat_w;
   logic [31:0] dat_r;
   logic [7:0]  rq;
   logic [9:0]  fr;
   int          error_cnt, comparisons;

   ssbr_serial ssbr_serial_i (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .rxd(rxd),
      .txd(txd), .sclk(), .lowpower_req(lp), .irq(irq));
   ssbr_far_end ssbr_far_end_i (.mclk(mclk), .txd(txd), .rxd(rxd));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic cycle; request held until ack is sampled high
   task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= {24'h0, d};
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) chk("ack", 8'h01, 8'h00);
      rq = dat_r[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
      xfer(1'b0, a, 8'h00);
      chk("register", e, rq & m);
   endtask

   task automatic finish_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end

   initial begin
      error_cnt = 0;
      comparisons = 0;
      {cyc, stb, we, lp, adr, dat_w} = '0;
      arst_n = 1'b0;
      repeat (20) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      rd(5'h00, 8'h84, 8'hFF);
      rd(5'h04, 8'hFF, 8'hFF);
      rd(5'h1C, 8'h00, 8'hFF);
      xfer(1'b1, 5'h04, 8'h00);
      rd(5'h04, 8'h00, 8'hFF);
      xfer(1'b1, 5'h00, 8'h80);
      rd(5'h00, 8'h84, 8'hFF);
      lp <= 1'b1;
      repeat (4) @(posedge mclk);
      lp <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(5'h04, 8'hFF, 8'hFF);
      xfer(1'b1, 5'h04, 8'h00);
      // Transmit with multiproc bit, fastest rate: 64 clocks per bit
      xfer(1'b1, 5'h08, 8'h0A);
      xfer(1'b1, 5'h00, 8'h81);
      xfer(1'b1, 5'h18, 8'h0C);
      xfer(1'b1, 5'h14, 8'h0F);
      fork
         ssbr_far_end_i.recv(fr);
         begin
            xfer(1'b1, 5'h0C, 8'hA5);
            rd(5'h00, 8'h00, 8'h04);
         end
      join
      chk("tx data", 8'hA5, fr[7:0]);
      chk("tx mpbit", 8'h03, {6'h0, fr[9:8]});
      repeat (64) @(posedge mclk);
      rd(5'h00, 8'h04, 8'h04);
      chk("irq", 8'h01, {7'h0, irq});
      xfer(1'b1, 5'h14, 8'h04);
      // The interrupt output lags its status by one register stage
      @(posedge mclk);
      chk("irq", 8'h00, {7'h0, irq});
      xfer(1'b1, 5'h0C, 8'h00);
      xfer(1'b1, 5'h08, 8'h00);
      rd(5'h00, 8'h04, 8'h04);
      xfer(1'b1, 5'h00, 8'h00);
      rd(5'h00, 8'h00, 8'h04);
      // Receive with even parity, first a corrupted frame
      xfer(1'b1, 5'h08, 8'h11);
      ssbr_far_end_i.send(8'h3C, 1'b1);
      rd(5'h00, 8'h08, 8'h48);
      rd(5'h10, 8'h3C, 8'hFF);
      chk("irq", 8'h01, {7'h0, irq});
      xfer(1'b1, 5'h00, 8'h08);
      rd(5'h00, 8'h08, 8'h08);
      xfer(1'b1, 5'h08, 8'h10);
      rd(5'h00, 8'h08, 8'h08);
      xfer(1'b1, 5'h08, 8'h11);
      ssbr_far_end_i.send(8'h55, 1'b0);
      rd(5'h00, 8'h08, 8'h48);
      xfer(1'b1, 5'h00, 8'h00);
      rd(5'h00, 8'h00, 8'h08);
      ssbr_far_end_i.send(8'h55, 1'b0);
      rd(5'h00, 8'h40, 8'h48);
      rd(5'h10, 8'h55, 8'hFF);
      xfer(1'b1, 5'h14, 8'h0F);
      repeat (2) @(posedge mclk);
      chk("irq", 8'h00, {7'h0, irq});
      finish_test();
   end
endmodule // ssbr_serial_bench
